// ### rtl/cmit_defines.svh
// Purpose: Constants of the compare match interval timer
// Assumes: Included by its bare name, definitions only
// Notes:   Register offsets are word indices; byte address is index times four
//
// Behaviour
// - Clock select code 1,1,0 advances the counter once every four system clocks.
// - The upper half counter is an 8-bit software accessible up-counter stepped by its clock.
// - The counter is compared with the compare value all the time and equality is a match.
// - Bit 6 of the flag register becomes 1 after a match and reads 0 while none occurred.
// - Bit 7 of the flag register becomes 1 after a counter overflow and reads 0 otherwise.
// - An overflow raises an interrupt request only while enable bit 5 is 1.
// - With clear bit 4 at 1 a match returns the counter to zero, at 0 it keeps running.
// - Software picks the counter clock from system clock /4, /16, /32 or watch clock /4.
// - The control register also picks 16-bit or split 8-bit mode and sets both output pins.
`ifndef CMIT_DEFINES_SVH
`define CMIT_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CMIT_IDX_CTRL   16'hffb6
`define CMIT_IDX_FLAG   16'hffb7
`define CMIT_IDX_CNTH   16'hffb8
`define CMIT_IDX_CNTL   16'hffb9
`define CMIT_IDX_OCR    16'hffba
`define CMIT_IDX_IST    16'hffbb
`define CMIT_IDX_IMSK   16'hffbc
`define CMIT_IDX_W      18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMIT_OVF_BIT    7
`define CMIT_CMF_BIT    6
`define CMIT_OVIE_BIT   5
`define CMIT_CCLR_BIT   4
`define CMIT_LVLH_BIT   7
`define CMIT_MODE_BIT   6
`define CMIT_LVLL_BIT   3
`define CMIT_IST_OVF    0
`define CMIT_IST_CMF    1

// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define CMIT_CKS_DIV32  3'h4
`define CMIT_CKS_DIV16  3'h5
`define CMIT_CKS_DIV4   3'h6
`define CMIT_CKS_WATCH  3'h7

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CMIT_CTRL_RST   8'h00
`define CMIT_CNT_RST    8'h00
`define CMIT_OCR_RST    8'hff
`define CMIT_CNT_MAX    8'hff
`define CMIT_DIV4_LAST  2'h3
`define CMIT_DIV16_LAST 4'hf
`define CMIT_DIV32_LAST 5'h1f

`endif

// ### rtl/cmit_pkg.sv
// Purpose: Types of the compare match interval timer
// Assumes: Used with cmit_defines.svh
// Notes:   State of each module is one packed struct
package cmit_pkg;

  typedef enum logic [2:0] {
    CMIT_R_NONE,
    CMIT_R_CTRL,
    CMIT_R_FLAG,
    CMIT_R_CNTH,
    CMIT_R_CNTL,
    CMIT_R_OCR,
    CMIT_R_IST,
    CMIT_R_IMSK
  } cmit_reg_e;

  typedef struct packed {
    logic [4:0] div_cnt;
    logic [1:0] watch_cnt;
    logic       tick_div4;
    logic       tick_div16;
    logic       tick_div32;
    logic       tick_watch4;
  } cmit_presc_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  ctrl;
    logic        ovf;
    logic        cmf;
    logic        ovie;
    logic        cclr;
    logic        ovf_arm;
    logic        cmf_arm;
    logic [7:0]  cnt_hi;
    logic [7:0]  cnt_lo;
    logic [7:0]  ocr;
    logic        eq_d;
    logic [1:0]  int_st;
    logic [1:0]  int_mask;
    logic        irq;
    logic        out_hi;
    logic        out_lo;
  } cmit_state_s;

endpackage

// ### rtl/cmit_prescaler.sv
// Purpose: Divided clock enables for the interval timer
// Assumes: watch_tick is a one-cycle pulse per watch clock period
// Notes:   All outputs are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "cmit_defines.svh"

module cmit_prescaler
  import cmit_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic watch_tick,
  output var  logic tick_div4,
  output var  logic tick_div16,
  output var  logic tick_div32,
  output var  logic tick_watch4
);

  cmit_presc_s st;
  cmit_presc_s nx;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb
  begin
    nx             = st;
    nx.div_cnt     = st.div_cnt + 5'h01;
    nx.tick_div4   = (st.div_cnt[1:0] == `CMIT_DIV4_LAST);
    nx.tick_div16  = (st.div_cnt[3:0] == `CMIT_DIV16_LAST);
    nx.tick_div32  = (st.div_cnt == `CMIT_DIV32_LAST);
    nx.tick_watch4 = watch_tick && (st.watch_cnt == `CMIT_DIV4_LAST);
    if (watch_tick)
    begin
      nx.watch_cnt = st.watch_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign tick_div4   = st.tick_div4;
  assign tick_div16  = st.tick_div16;
  assign tick_div32  = st.tick_div32;
  assign tick_watch4 = st.tick_watch4;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div4_rate_a : assert property (
    @(posedge clk) disable iff (!rstn)
    tick_div4 |=> !tick_div4 [*3] ##1 tick_div4)
    else $error("div4 enable not every fourth cycle");

  div16_gap_a : assert property (
    @(posedge clk) disable iff (!rstn)
    tick_div16 |=> !tick_div16 [*8])
    else $error("div16 enable too frequent");

endmodule // cmit_prescaler
`default_nettype wire

// ### rtl/cmit_timer.sv
// Purpose: Eight-bit compare match interval timer with APB registers
// Assumes: APB master, all inputs synchronous to clk (200 MHz)
// Notes:   One wait state on every access; unmapped addresses answer pslverr
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cmit_defines.svh"

module cmit_timer
  import cmit_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic              pready,
  output var  logic [31:0]       prdata,
  output var  logic              pslverr,
  input  wire logic              watch_tick,
  output var  logic              irq,
  output var  logic              timer_out_hi,
  output var  logic              timer_out_lo
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (ADDR_W < `CMIT_IDX_W)
  begin : g_addr_check
    $error("ADDR_W too narrow for register map");
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic at_idx(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    at_idx = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic cmit_reg_e reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = CMIT_R_NONE;
    if (at_idx(a, `CMIT_IDX_CTRL)) reg_sel = CMIT_R_CTRL;
    if (at_idx(a, `CMIT_IDX_FLAG)) reg_sel = CMIT_R_FLAG;
    if (at_idx(a, `CMIT_IDX_CNTH)) reg_sel = CMIT_R_CNTH;
    if (at_idx(a, `CMIT_IDX_CNTL)) reg_sel = CMIT_R_CNTL;
    if (at_idx(a, `CMIT_IDX_OCR))  reg_sel = CMIT_R_OCR;
    if (at_idx(a, `CMIT_IDX_IST))  reg_sel = CMIT_R_IST;
    if (at_idx(a, `CMIT_IDX_IMSK)) reg_sel = CMIT_R_IMSK;
  endfunction

  // Codes 0xx give no tick: external event input is not supported
  function automatic logic cks_tick(input logic [2:0] code, input logic t4,
                                    input logic t16, input logic t32, input logic tw);
    case (code)
      `CMIT_CKS_DIV4:  cks_tick = t4;
      `CMIT_CKS_DIV16: cks_tick = t16;
      `CMIT_CKS_DIV32: cks_tick = t32;
      `CMIT_CKS_WATCH: cks_tick = tw;
      default:         cks_tick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  logic tick_div4;
  logic tick_div16;
  logic tick_div32;
  logic tick_watch4;

  cmit_prescaler cmit_prescaler_inst (
    .clk         (clk),
    .rstn        (rstn),
    .watch_tick  (watch_tick),
    .tick_div4   (tick_div4),
    .tick_div16  (tick_div16),
    .tick_div32  (tick_div32),
    .tick_watch4 (tick_watch4)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  cmit_state_s st;
  cmit_state_s nx;
  cmit_reg_e   sel;
  logic        access;
  logic        wr_done;
  logic        rd_done;
  logic        t_lo;
  logic        t_hi;
  logic        lo_wrap;
  logic        eq;
  logic        match_evt;
  logic        clr_hi;
  logic        ovf_evt;
  logic [7:0]  rd_val;
  logic [7:0]  wd;

  always_comb
  begin
    sel     = reg_sel(paddr);
    access  = psel && penable;
    wr_done = access && st.pready && pwrite;
    rd_done = access && st.pready && !pwrite;
    wd      = pwdata[7:0];
  end

  // ----------------------------------------
  // Counter clocking and compare
  // ----------------------------------------
  always_comb
  begin
    t_lo    = cks_tick(st.ctrl[2:0], tick_div4, tick_div16, tick_div32, tick_watch4);
    lo_wrap = t_lo && (st.cnt_lo == `CMIT_CNT_MAX);
    // Mode bit low chains the upper half on the lower overflow
    t_hi    = st.ctrl[`CMIT_MODE_BIT]
              ? cks_tick(st.ctrl[6:4], tick_div4, tick_div16, tick_div32, tick_watch4)
              : lo_wrap;
    eq        = (st.cnt_hi == st.ocr);
    // Only the first cycle of equality counts, so a stopped clock gives one event
    match_evt = eq && !st.eq_d;
    clr_hi    = t_hi && eq && st.cclr;
    ovf_evt   = t_hi && !clr_hi && (st.cnt_hi == `CMIT_CNT_MAX);
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_val = 8'h00;
    case (sel)
      CMIT_R_CTRL: rd_val = st.ctrl;
      CMIT_R_FLAG: rd_val = {st.ovf, st.cmf, st.ovie, st.cclr, 4'h0};
      CMIT_R_CNTH: rd_val = st.cnt_hi;
      CMIT_R_CNTL: rd_val = st.cnt_lo;
      CMIT_R_OCR:  rd_val = st.ocr;
      CMIT_R_IST:  rd_val = {6'h00, st.int_st};
      CMIT_R_IMSK: rd_val = {6'h00, st.int_mask};
      default:     rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nx      = st;
    nx.eq_d = eq;

    // Bus answer, one wait state
    nx.pready  = access && !st.pready;
    nx.pslverr = nx.pready && (sel == CMIT_R_NONE);
    nx.prdata  = (nx.pready && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;

    // Counters
    if (t_lo)
    begin
      nx.cnt_lo = st.cnt_lo + 8'h01;
    end
    if (clr_hi)
    begin
      nx.cnt_hi = `CMIT_CNT_RST;
    end
    else if (t_hi)
    begin
      nx.cnt_hi = st.cnt_hi + 8'h01;
    end
    if (match_evt)
    begin
      nx.out_hi = !st.out_hi;
    end

    // Register writes; a software write to a counter beats a tick
    if (wr_done)
    begin
      case (sel)
        CMIT_R_CTRL:
        begin
          nx.ctrl   = wd;
          nx.out_hi = wd[`CMIT_LVLH_BIT];
          nx.out_lo = wd[`CMIT_LVLL_BIT];
        end
        CMIT_R_FLAG:
        begin
          nx.ovie = wd[`CMIT_OVIE_BIT];
          nx.cclr = wd[`CMIT_CCLR_BIT];
          if (!wd[`CMIT_OVF_BIT] && st.ovf_arm)
          begin
            nx.ovf     = 1'b0;
            nx.ovf_arm = 1'b0;
          end
          if (!wd[`CMIT_CMF_BIT] && st.cmf_arm)
          begin
            nx.cmf     = 1'b0;
            nx.cmf_arm = 1'b0;
          end
        end
        CMIT_R_CNTH: nx.cnt_hi   = wd;
        CMIT_R_CNTL: nx.cnt_lo   = wd;
        CMIT_R_OCR:  nx.ocr      = wd;
        CMIT_R_IMSK: nx.int_mask = wd[1:0];
        default:     nx.int_mask = st.int_mask;
      endcase
    end

    // Flag read side effects use the value actually returned; a status read clears both bits
    if (rd_done && (sel == CMIT_R_FLAG))
    begin
      nx.ovf_arm = st.prdata[`CMIT_OVF_BIT];
      nx.cmf_arm = st.prdata[`CMIT_CMF_BIT];
    end
    if (rd_done && (sel == CMIT_R_IST))
    begin
      nx.int_st = 2'h0;
    end

    // Events last, so a set in the clearing cycle is kept
    if (ovf_evt)
    begin
      nx.ovf = 1'b1;
    end
    if (match_evt)
    begin
      nx.cmf = 1'b1;
    end
    nx.int_st[`CMIT_IST_OVF] = nx.int_st[`CMIT_IST_OVF] || ovf_evt;
    nx.int_st[`CMIT_IST_CMF] = nx.int_st[`CMIT_IST_CMF] || match_evt;

    // Overflow request also needs the enable bit in the flag register
    nx.irq = (nx.int_st[`CMIT_IST_OVF] && nx.int_mask[`CMIT_IST_OVF] && nx.ovie)
          || (nx.int_st[`CMIT_IST_CMF] && nx.int_mask[`CMIT_IST_CMF]);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st        <= '0;
      st.ctrl   <= `CMIT_CTRL_RST;
      st.cnt_hi <= `CMIT_CNT_RST;
      st.cnt_lo <= `CMIT_CNT_RST;
      st.ocr    <= `CMIT_OCR_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  assign pready       = st.pready;
  assign prdata       = st.prdata;
  assign pslverr      = st.pslverr;
  assign irq          = st.irq;
  assign timer_out_hi = st.out_hi;
  assign timer_out_lo = st.out_lo;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div4_select_a : assert property (
    @(posedge clk) disable iff (!rstn)
    (st.ctrl[6:4] == `CMIT_CKS_DIV4) && tick_div4 |-> t_hi)
    else $error("div4 code did not step upper counter");

  count_step_a : assert property (
    @(posedge clk) disable iff (!rstn)
    t_hi && !clr_hi && !(wr_done && (sel == CMIT_R_CNTH))
    |=> st.cnt_hi == $past(st.cnt_hi) + 8'h01)
    else $error("upper counter did not step");

  count_hold_a : assert property (
    @(posedge clk) disable iff (!rstn)
    !t_hi && !wr_done |=> $stable(st.cnt_hi))
    else $error("upper counter moved without tick");

  match_detect_a : assert property (
    @(posedge clk) disable iff (!rstn)
    (st.cnt_hi == st.ocr) && !st.eq_d |=> st.cmf && st.int_st[`CMIT_IST_CMF] && st.eq_d)
    else $error("match not flagged");

  cmf_cause_a : assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(st.cmf) |-> $past(st.cnt_hi) == $past(st.ocr))
    else $error("match flag set without match");

  ovf_flag_a : assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(st.ovf) |-> $past(st.cnt_hi) == `CMIT_CNT_MAX && $past(t_hi))
    else $error("overflow flag without overflow");

  ovf_irq_gate_a : assert property (
    @(posedge clk) disable iff (!rstn)
    st.irq |-> (st.ovie && st.int_st[0] && st.int_mask[0])
               || (st.int_st[1] && st.int_mask[1]))
    else $error("interrupt without enabled cause");

  clear_match_a : assert property (
    @(posedge clk) disable iff (!rstn)
    t_hi && st.cclr && (st.cnt_hi == st.ocr) && !(wr_done && (sel == CMIT_R_CNTH))
    |=> st.cnt_hi == 8'h00)
    else $error("counter not cleared on match");

  pin_level_a : assert property (
    @(posedge clk) disable iff (!rstn)
    wr_done && (sel == CMIT_R_CTRL)
    |=> timer_out_hi == $past(pwdata[7]) && timer_out_lo == $past(pwdata[3]))
    else $error("output pins not set from control write");

  flag_keep_a : assert property (
    @(posedge clk) disable iff (!rstn)
    st.ovf && !st.ovf_arm ##1 st.ovf_arm == 1'b0 [*2] |-> st.ovf)
    else $error("overflow flag cleared without read");

  ack_timing_a : assert property (
    @(posedge clk) disable iff (!rstn)
    psel && !penable ##1 psel && penable |=> pready)
    else $error("access not answered after one wait");

endmodule // cmit_timer
`default_nettype wire

// ### test/compare_match_interval_timer_tb.sv
// Purpose: Self-checking bench of the compare match interval timer
// Assumes: APB slave answers after one wait state; byte address is index times four
// Notes:   Counter rates are measured as the difference of two reads a fixed time apart
`timescale 1ns/1ps
`default_nettype none
`include "cmit_defines.svh"

`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("BAD time %0t got %h expected %h", $time, (a), (e)); \
    end \
  end

module compare_match_interval_timer_tb;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        watch_tick;
  logic        irq;
  logic        timer_out_hi;
  logic        timer_out_lo;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          comparisons;

  cmit_timer #(
    .ADDR_W (18)
  ) cmit_timer_inst (
    .clk          (clk),
    .rstn         (rstn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .watch_tick   (watch_tick),
    .irq          (irq),
    .timer_out_hi (timer_out_hi),
    .timer_out_lo (timer_out_lo)
  );

  // ----------------------------------------
  // Clock and watch pulses
  // ----------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // A pulse every second clock, so watch/4 ticks every eight clocks
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      watch_tick <= 1'b0;
    end
    else
    begin
      watch_tick <= ~watch_tick;
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // Ready is sampled at rising edges; the request stands until it is seen high
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("BAD time %0t got %h expected %h", $time, pready, 1'b1);
      results();
    end
    else
    begin
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  task automatic settle();
    @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rdc(`CMIT_IDX_CTRL, 8'h00);
    rdc(`CMIT_IDX_FLAG, 8'h00);
    rdc(`CMIT_IDX_CNTH, 8'h00);
    rdc(`CMIT_IDX_OCR, 8'hff);
    rdc(`CMIT_IDX_IST, 8'h00);
    rdc(`CMIT_IDX_IMSK, 8'h00);
    apb(1'b0, 16'hffbd, 8'h00);
    `CHK({er, rd}, 33'h100000000)
    $display("test reset finished");
  endtask

  task automatic rate(input logic [2:0] code, input logic [7:0] e);
    logic [7:0] first;
    wr(`CMIT_IDX_CNTH, 8'h00);
    wr(`CMIT_IDX_CTRL, {1'b0, code, 4'h0});
    apb(1'b0, `CMIT_IDX_CNTH, 8'h00);
    first = rd[7:0];
    // 156 idle edges plus four per access: 160 clocks between samples
    repeat (156) @(posedge clk);
    apb(1'b0, `CMIT_IDX_CNTH, 8'h00);
    `CHK(8'(rd[7:0] - first), e)
    wr(`CMIT_IDX_CTRL, 8'h00);
  endtask

  task automatic test_rates();
    rate(`CMIT_CKS_DIV4, 8'h28);
    rate(`CMIT_CKS_DIV16, 8'h0a);
    rate(`CMIT_CKS_DIV32, 8'h05);
    rate(`CMIT_CKS_WATCH, 8'h14);
    $display("test rates finished");
  endtask

  task automatic test_pins();
    wr(`CMIT_IDX_CTRL, 8'h88);
    settle();
    `CHK({timer_out_hi, timer_out_lo}, 2'b11)
    // Upper select 000 chains the halves into one 16-bit counter
    wr(`CMIT_IDX_CNTH, 8'h00);
    wr(`CMIT_IDX_CNTL, 8'hf0);
    wr(`CMIT_IDX_CTRL, 8'h06);
    settle();
    `CHK({timer_out_hi, timer_out_lo}, 2'b00)
    repeat (100) @(posedge clk);
    wr(`CMIT_IDX_CTRL, 8'h00);
    rdc(`CMIT_IDX_CNTH, 8'h01);
    $display("test pins finished");
  endtask

  task automatic test_match();
    wr(`CMIT_IDX_OCR, 8'h05);
    wr(`CMIT_IDX_FLAG, 8'h10);
    wr(`CMIT_IDX_IMSK, 8'h02);
    wr(`CMIT_IDX_CNTH, 8'h00);
    wr(`CMIT_IDX_CTRL, 8'h60);
    repeat (60) @(posedge clk);
    wr(`CMIT_IDX_CTRL, 8'h00);
    apb(1'b0, `CMIT_IDX_CNTH, 8'h00);
    `CHK(rd[7:0] <= 8'h05, 1'b1)
    settle();
    `CHK(irq, 1'b1)
    rdc(`CMIT_IDX_FLAG, 8'h50);
    wr(`CMIT_IDX_FLAG, 8'h10);
    rdc(`CMIT_IDX_FLAG, 8'h10);
    wr(`CMIT_IDX_FLAG, 8'h50);
    rdc(`CMIT_IDX_FLAG, 8'h10);
    rdc(`CMIT_IDX_IST, 8'h02);
    settle();
    `CHK(irq, 1'b0)
    // A zero written without a prior read of the set flag must not clear it
    wr(`CMIT_IDX_CTRL, 8'h60);
    repeat (40) @(posedge clk);
    wr(`CMIT_IDX_CTRL, 8'h00);
    wr(`CMIT_IDX_FLAG, 8'h10);
    rdc(`CMIT_IDX_FLAG, 8'h50);
    wr(`CMIT_IDX_FLAG, 8'h00);
    rdc(`CMIT_IDX_FLAG, 8'h00);
    rdc(`CMIT_IDX_IST, 8'h02);
    $display("test match finished");
  endtask

  task automatic test_overflow();
    // Match passes on the way to the wrap; with clearing off it must not stop the count
    wr(`CMIT_IDX_OCR, 8'h80);
    wr(`CMIT_IDX_FLAG, 8'h20);
    wr(`CMIT_IDX_IMSK, 8'h01);
    wr(`CMIT_IDX_CNTH, 8'h7e);
    wr(`CMIT_IDX_CTRL, 8'h60);
    repeat (560) @(posedge clk);
    wr(`CMIT_IDX_CTRL, 8'h00);
    settle();
    `CHK(irq, 1'b1)
    rdc(`CMIT_IDX_FLAG, 8'he0);
    rdc(`CMIT_IDX_IST, 8'h03);
    settle();
    `CHK(irq, 1'b0)
    wr(`CMIT_IDX_FLAG, 8'h00);
    rdc(`CMIT_IDX_FLAG, 8'h00);
    wr(`CMIT_IDX_CNTH, 8'hfc);
    wr(`CMIT_IDX_CTRL, 8'h60);
    repeat (40) @(posedge clk);
    wr(`CMIT_IDX_CTRL, 8'h00);
    settle();
    `CHK(irq, 1'b0)
    rdc(`CMIT_IDX_IST, 8'h01);
    rdc(`CMIT_IDX_FLAG, 8'h80);
    $display("test overflow finished");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_count   = 0;
    comparisons = 0;
    rstn        = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 18'h00000;
    pwdata      = 32'h00000000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_rates();
    test_pins();
    test_match();
    test_overflow();
    results();
  end

endmodule // compare_match_interval_timer_tb
`default_nettype wire
